/* File: logic/irp_pkg.sv */
package irp_pkg;

    // direct-mapped port addresses, full 16-bit decode
    localparam logic [15:0] SETUP_IDX_PORT  = 16'h0022;
    localparam logic [15:0] SETUP_DATA_PORT = 16'h0023;
    localparam logic [15:0] CLOCK_IDX_PORT  = 16'h0070;
    localparam logic [15:0] CLOCK_DATA_PORT = 16'h0071;
    localparam logic [15:0] MONO_IDX_PORT   = 16'h03b4;
    localparam logic [15:0] MONO_DATA_PORT  = 16'h03b5;
    localparam logic [15:0] COLOR_IDX_PORT  = 16'h03d4;
    localparam logic [15:0] COLOR_DATA_PORT = 16'h03d5;
    localparam logic [15:0] CARD_IDX_PORT   = 16'h03e0;
    localparam logic [15:0] CARD_DATA_PORT  = 16'h03e1;

    // indexed spaces, used as array positions
    localparam int NUM_SPACES = 4;
    localparam int SP_SETUP   = 0;
    localparam int SP_CLOCK   = 1;
    localparam int SP_GFX     = 2;
    localparam int SP_CARD    = 3;

    localparam logic [7:0] IDX_RST = 8'h00;

    // clock space: time registers first, battery RAM above them
    localparam logic [6:0] CLK_REG_COUNT = 7'h0e;
    localparam int         RAM_BYTES     = 114;

    // setup space group start indexes
    localparam logic [7:0] G_MEMCTL  = 8'h00;
    localparam logic [7:0] G_GAP     = 8'h08;
    localparam logic [7:0] G_CACHE   = 8'h10;
    localparam logic [7:0] G_ROM     = 8'h20;
    localparam logic [7:0] G_MAPPING = 8'h30;
    localparam logic [7:0] G_PINMUX  = 8'h38;
    localparam logic [7:0] G_PWRMODE = 8'h40;
    localparam logic [7:0] G_WAKE    = 8'h50;
    localparam logic [7:0] G_ACTIV   = 8'h60;
    localparam logic [7:0] G_BATT    = 8'h70;
    localparam logic [7:0] G_CLKCTL  = 8'h80;
    localparam logic [7:0] G_DEBUG   = 8'h88;
    localparam logic [7:0] G_SMI     = 8'h90;
    localparam logic [7:0] G_GPIO    = 8'ha0;
    localparam logic [7:0] G_KBD     = 8'hc0;
    localparam logic [7:0] G_PERIPH  = 8'hd0;
    localparam logic [7:0] G_ISA     = 8'he0;
    localparam logic [7:0] G_IR      = 8'hea;
    localparam logic [7:0] G_CARDCFG = 8'hf0;
    localparam logic [7:0] G_REV     = 8'hff;

    typedef enum logic [4:0] {
        GRP_MEMCTL, GRP_GAP, GRP_CACHE, GRP_ROM, GRP_MAPPING, GRP_PINMUX,
        GRP_PWRMODE, GRP_WAKE, GRP_ACTIV, GRP_BATT, GRP_CLKCTL, GRP_DEBUG,
        GRP_SMI, GRP_GPIO, GRP_KBD, GRP_PERIPH, GRP_ISA, GRP_IR,
        GRP_CARDCFG, GRP_REV
    } irp_group_t;

    // one host i/o cycle, valid for the cycle a strobe is high
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wide;
        logic        wr;
        logic        rd;
    } irp_io_req_t;

    // port decode result
    typedef struct packed {
        logic       hit;
        logic       data;
        logic [1:0] space;
    } irp_hit_t;

    // access presented to one indexed space
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } irp_space_acc_t;

endpackage : irp_pkg

/* File: logic/irp_clock_ram.sv */
`timescale 1ns/1ps

// battery-backed byte store above the clock's time registers
module irp_clock_ram (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       wr,
    input  wire logic [6:0] index,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);

    // no reset on the array: contents must survive a core reset
    logic [7:0] mem [irp_pkg::RAM_BYTES];
    logic [6:0] slot;

    assign slot = index - irp_pkg::CLK_REG_COUNT;

    // byte write at the selected slot
    always_ff @(posedge core_clk) begin
        if (wr) begin
            mem[slot] <= wdata;
        end
    end

    // combinational read, registered by the port decoder
    assign rdata = mem[slot];

    AST_RAM_KEEPS: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr |=> (mem[$past(slot)] == $past(wdata)))
        else $error("ram byte not stored");

endmodule : irp_clock_ram

/* File: logic/irp_port_decode.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Ports 0022h/0023h are index/data of the chip setup space.
// - Ports 0070h/0071h are index/data of the clock and battery RAM space.
// - Graphics pair sits at 03B4h/03B5h for mono, 03D4h/03D5h for colour.
// - Card controller pair at 03E0h/03E1h, only when that controller exists.
// - Host writes index first; data accesses go to the stored index.
// - Each space keeps its written index until the next index write.
// - A 16-bit write to an index port: low byte index, high byte data.
// - Setup and clock ports decode only with upper address byte zero.
// - Clock space reaches time registers and 114 bytes of battery RAM.
// - Groups align to 8/16 bytes except IR EAh and rev FFh; memory setup 00h-07h, cache at 10h.
// - Groups: ROM 20h, mapping 30h, pins 38h, power 40h/50h/60h.
// - Groups: battery 70h, clock 80h, debug 88h, SMI 90h, GPIO A0h.
// - Groups: keyboard C0h, peripheral D0h, ISA E0h, IR EAh, card F0h, rev FFh.
// - Card configuration lives in setup space; runtime control in card space.
module irp_port_decode (
    input  wire logic                                   core_clk,
    input  wire logic                                   rst_b,
    input  wire irp_pkg::irp_io_req_t                   io_req,
    output logic                                        io_hit,
    output logic                                        io_rvalid,
    output logic [7:0]                                  io_rdata,
    input  wire logic                                   color_mode,
    input  wire logic                                   card_present,
    output irp_pkg::irp_space_acc_t [irp_pkg::NUM_SPACES-1:0] space_acc,
    input  wire logic [irp_pkg::NUM_SPACES-1:0][7:0]    space_rdata,
    output irp_pkg::irp_group_t                         setup_group,
    output logic                                        setup_card_cfg
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // address to space; data port is the odd address of each pair
    function automatic irp_pkg::irp_hit_t port_decode(
        input logic [15:0] a,
        input logic        color,
        input logic        card
    );
        irp_pkg::irp_hit_t h;
        h       = '0;
        h.data  = a[0];
        if (a[15:1] == irp_pkg::SETUP_IDX_PORT[15:1]) begin
            h.hit   = 1'b1;
            h.space = 2'(irp_pkg::SP_SETUP);
        end else if (a[15:1] == irp_pkg::CLOCK_IDX_PORT[15:1]) begin
            h.hit   = 1'b1;
            h.space = 2'(irp_pkg::SP_CLOCK);
        end else if (!color && a[15:1] == irp_pkg::MONO_IDX_PORT[15:1]) begin
            h.hit   = 1'b1;
            h.space = 2'(irp_pkg::SP_GFX);
        end else if (color && a[15:1] == irp_pkg::COLOR_IDX_PORT[15:1]) begin
            h.hit   = 1'b1;
            h.space = 2'(irp_pkg::SP_GFX);
        end else if (card && a[15:1] == irp_pkg::CARD_IDX_PORT[15:1]) begin
            h.hit   = 1'b1;
            h.space = 2'(irp_pkg::SP_CARD);
        end
        return h;
    endfunction : port_decode

    // setup index to functional group, highest start first
    function automatic irp_pkg::irp_group_t group_of(input logic [7:0] i);
        irp_pkg::irp_group_t g;
        if      (i >= irp_pkg::G_REV)     g = irp_pkg::GRP_REV;
        else if (i >= irp_pkg::G_CARDCFG) g = irp_pkg::GRP_CARDCFG;
        else if (i >= irp_pkg::G_IR)      g = irp_pkg::GRP_IR;
        else if (i >= irp_pkg::G_ISA)     g = irp_pkg::GRP_ISA;
        else if (i >= irp_pkg::G_PERIPH)  g = irp_pkg::GRP_PERIPH;
        else if (i >= irp_pkg::G_KBD)     g = irp_pkg::GRP_KBD;
        else if (i >= irp_pkg::G_GPIO)    g = irp_pkg::GRP_GPIO;
        else if (i >= irp_pkg::G_SMI)     g = irp_pkg::GRP_SMI;
        else if (i >= irp_pkg::G_DEBUG)   g = irp_pkg::GRP_DEBUG;
        else if (i >= irp_pkg::G_CLKCTL)  g = irp_pkg::GRP_CLKCTL;
        else if (i >= irp_pkg::G_BATT)    g = irp_pkg::GRP_BATT;
        else if (i >= irp_pkg::G_ACTIV)   g = irp_pkg::GRP_ACTIV;
        else if (i >= irp_pkg::G_WAKE)    g = irp_pkg::GRP_WAKE;
        else if (i >= irp_pkg::G_PWRMODE) g = irp_pkg::GRP_PWRMODE;
        else if (i >= irp_pkg::G_PINMUX)  g = irp_pkg::GRP_PINMUX;
        else if (i >= irp_pkg::G_MAPPING) g = irp_pkg::GRP_MAPPING;
        else if (i >= irp_pkg::G_ROM)     g = irp_pkg::GRP_ROM;
        else if (i >= irp_pkg::G_CACHE)   g = irp_pkg::GRP_CACHE;
        else if (i >= irp_pkg::G_GAP)     g = irp_pkg::GRP_GAP;
        else                              g = irp_pkg::GRP_MEMCTL;
        return g;
    endfunction : group_of

    // ------------------------------------------------------------------
    // decode of the current cycle
    // ------------------------------------------------------------------

    irp_pkg::irp_hit_t dec;
    logic              idx_wr;
    logic              idx_rd;
    logic              dat_wr;
    logic              dat_rd;
    logic              split;
    logic [7:0]        tgt_index;
    logic [7:0]        tgt_wdata;
    logic [7:0]        idx_q [irp_pkg::NUM_SPACES];

    assign dec    = port_decode(io_req.addr, color_mode, card_present);
    assign io_hit = dec.hit & (io_req.wr | io_req.rd);

    // a wide index write also carries a data byte in the high lane
    assign split  = io_req.wr & dec.hit & ~dec.data & io_req.wide;
    assign idx_wr = io_req.wr & dec.hit & ~dec.data;
    assign idx_rd = io_req.rd & dec.hit & ~dec.data;
    assign dat_wr = (io_req.wr & dec.hit & dec.data) | split;
    assign dat_rd = io_req.rd & dec.hit & dec.data;

    // split write uses the index being written, not the stale one
    always_comb begin
        if (split) begin
            tgt_index = io_req.wdata[7:0];
            tgt_wdata = io_req.wdata[15:8];
        end else begin
            tgt_index = idx_q[dec.space];
            tgt_wdata = io_req.wdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // index registers, one per space
    // ------------------------------------------------------------------

    // the index holds until software writes its index port again
    for (genvar s = 0; s < irp_pkg::NUM_SPACES; s++) begin : g_index
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                idx_q[s] <= irp_pkg::IDX_RST;
            end else if (idx_wr && dec.space == 2'(s)) begin
                idx_q[s] <= io_req.wdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // clock space: time registers outside, battery bytes inside
    // ------------------------------------------------------------------

    logic       clk_space;
    logic       ram_sel;
    logic [7:0] ram_rdata;

    // bit 7 of the clock index does not take part in the byte address
    assign clk_space = dec.space == 2'(irp_pkg::SP_CLOCK);
    assign ram_sel   = clk_space & (tgt_index[6:0] >= irp_pkg::CLK_REG_COUNT);

    irp_clock_ram u_clock_ram (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .wr       (dat_wr & ram_sel),
        .index    (tgt_index[6:0]),
        .wdata    (tgt_wdata),
        .rdata    (ram_rdata)
    );

    // ------------------------------------------------------------------
    // access presented to each space
    // ------------------------------------------------------------------

    // battery bytes are served here, so the clock space sees no strobe
    for (genvar s = 0; s < irp_pkg::NUM_SPACES; s++) begin : g_acc
        logic here;
        assign here               = dec.space == 2'(s) && !(s == irp_pkg::SP_CLOCK && ram_sel);
        assign space_acc[s].wr    = dat_wr & here;
        assign space_acc[s].rd    = dat_rd & here;
        assign space_acc[s].index = (dec.space == 2'(s)) ? tgt_index : idx_q[s];
        assign space_acc[s].wdata = tgt_wdata;
    end

    // ------------------------------------------------------------------
    // read answer, one cycle after the read strobe
    // ------------------------------------------------------------------

    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic       rvalid_q;

    // unmapped reads answer 00h with io_hit low
    always_comb begin
        rdata_d = 8'h00;
        if (idx_rd) begin
            rdata_d = idx_q[dec.space];
        end else if (dat_rd && ram_sel) begin
            rdata_d = ram_rdata;
        end else if (dat_rd) begin
            rdata_d = space_rdata[dec.space];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= io_req.rd ? rdata_d : rdata_q;
            rvalid_q <= io_req.rd;
        end
    end

    assign io_rdata  = rdata_q;
    assign io_rvalid = rvalid_q;

    // ------------------------------------------------------------------
    // group of the current setup index
    // ------------------------------------------------------------------

    irp_pkg::irp_group_t group_q;

    // tracks the index register, so it follows split writes as well
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            group_q <= irp_pkg::GRP_MEMCTL;
        end else if (idx_wr && dec.space == 2'(irp_pkg::SP_SETUP)) begin
            group_q <= group_of(io_req.wdata[7:0]);
        end
    end

    assign setup_group    = group_q;
    // socket count and dma options are here, never in the card space
    assign setup_card_cfg = group_q == irp_pkg::GRP_CARDCFG;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------

    AST_SETUP_IDX: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.wr && !io_req.wide && io_req.addr == irp_pkg::SETUP_IDX_PORT)
        |=> idx_q[irp_pkg::SP_SETUP] == $past(io_req.wdata[7:0]))
        else $error("setup index not taken");

    AST_CLOCK_DATA: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.wr && io_req.addr == irp_pkg::CLOCK_DATA_PORT)
        |-> (space_acc[irp_pkg::SP_CLOCK].wr ^ ram_sel) && io_hit)
        else $error("clock data write not routed");

    AST_GFX_MODE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.wr && io_req.addr == (color_mode ? irp_pkg::MONO_IDX_PORT
                                                  : irp_pkg::COLOR_IDX_PORT))
        |-> !io_hit ##1 $stable(idx_q[irp_pkg::SP_GFX]))
        else $error("graphics pair answered in wrong mode");

    AST_CARD_ABSENT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!card_present && io_req.rd && io_req.addr == irp_pkg::CARD_DATA_PORT)
        |-> !io_hit && !space_acc[irp_pkg::SP_CARD].rd)
        else $error("card port answered without controller");

    AST_DATA_ROUTE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.rd && io_req.addr == irp_pkg::SETUP_DATA_PORT)
        |-> space_acc[irp_pkg::SP_SETUP].rd
            && space_acc[irp_pkg::SP_SETUP].index == idx_q[irp_pkg::SP_SETUP])
        else $error("data read not at stored index");

    AST_IDX_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(io_req.wr && io_req.addr == irp_pkg::CLOCK_IDX_PORT)
        |=> $stable(idx_q[irp_pkg::SP_CLOCK]))
        else $error("clock index changed without write");

    AST_SPLIT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.wr && io_req.wide && io_req.addr == irp_pkg::SETUP_IDX_PORT)
        |-> space_acc[irp_pkg::SP_SETUP].wr
            && space_acc[irp_pkg::SP_SETUP].wdata == io_req.wdata[15:8]
            && space_acc[irp_pkg::SP_SETUP].index == io_req.wdata[7:0])
        else $error("wide index write not split");

    AST_NARROW_ADDR: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.addr[15:8] != 8'h00 && io_req.addr[7:0] == irp_pkg::SETUP_IDX_PORT[7:0])
        |-> !dec.hit)
        else $error("setup port aliased above 8-bit range");

    AST_READBACK: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.rd && io_req.addr == irp_pkg::SETUP_IDX_PORT)
        |=> io_rvalid && io_rdata == $past(idx_q[irp_pkg::SP_SETUP]))
        else $error("index readback wrong");

    AST_GROUP: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(io_rvalid) |-> setup_group == group_of(idx_q[irp_pkg::SP_SETUP]))
        else $error("setup group out of step with index");

    // setup index write, shared by the group checks
    logic setup_iw;
    assign setup_iw = idx_wr && dec.space == 2'(irp_pkg::SP_SETUP);

    // battery bytes never strobe the outside clock space
    AST_RAM_ROUTE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (dat_wr && clk_space && tgt_index[6:0] >= irp_pkg::CLK_REG_COUNT)
        |-> !space_acc[irp_pkg::SP_CLOCK].wr)
        else $error("battery byte reached clock space");

    // setup index moves only on its own port
    AST_SETUP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
        !setup_iw
        |=> $stable(idx_q[irp_pkg::SP_SETUP]))
        else $error("setup index changed without write");

    // indexes below the gap are memory setup
    AST_GRP_MEM: assert property (@(posedge core_clk) disable iff (!rst_b)
        (setup_iw && io_req.wdata[7:0] < irp_pkg::G_GAP)
        |=> setup_group == irp_pkg::GRP_MEMCTL)
        else $error("memory setup index misgrouped");

    // pin group starts at its own index
    AST_GRP_PIN: assert property (@(posedge core_clk) disable iff (!rst_b)
        (setup_iw && io_req.wdata[7:0] == irp_pkg::G_PINMUX)
        |=> setup_group == irp_pkg::GRP_PINMUX)
        else $error("pin group start misgrouped");

    // debug group splits the clock block
    AST_GRP_DBG: assert property (@(posedge core_clk) disable iff (!rst_b)
        (setup_iw && io_req.wdata[7:0] == irp_pkg::G_DEBUG)
        |=> setup_group == irp_pkg::GRP_DEBUG)
        else $error("debug group start misgrouped");

    // last index is the revision, not card config
    AST_GRP_REV: assert property (@(posedge core_clk) disable iff (!rst_b)
        (setup_iw && io_req.wdata[7:0] == irp_pkg::G_REV)
        |=> setup_group == irp_pkg::GRP_REV)
        else $error("revision index misgrouped");

    // card config flag only inside its index range
    AST_CARD_CFG: assert property (@(posedge core_clk) disable iff (!rst_b)
        setup_card_cfg
        |-> idx_q[irp_pkg::SP_SETUP] >= irp_pkg::G_CARDCFG && idx_q[irp_pkg::SP_SETUP] < irp_pkg::G_REV)
        else $error("card config flag outside its group");

    // clock index reads back as well
    AST_READBACK_CLK: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.rd && io_req.addr == irp_pkg::CLOCK_IDX_PORT)
        |=> io_rvalid && io_rdata == $past(idx_q[irp_pkg::SP_CLOCK]))
        else $error("clock index readback wrong");

    // refused ports still answer, with zero
    AST_UNMAPPED_RD: assert property (@(posedge core_clk) disable iff (!rst_b)
        (io_req.rd && !dec.hit)
        |=> io_rvalid && io_rdata == 8'h00)
        else $error("unmapped read not zero");

endmodule : irp_port_decode

/* File: verif/irp_host_model.sv */
`timescale 1ns/1ps

// host side of the i/o bus: one strobe per call, dropped a cycle later
module irp_host_model (
    input  wire logic                 core_clk,
    output irp_pkg::irp_io_req_t      io_req,
    input  wire logic                 io_hit,
    input  wire logic                 io_rvalid,
    input  wire logic [7:0]           io_rdata
);
    initial io_req = '0;

    // strobe raised after the falling edge, hit sampled while it stands
    task automatic io_wr(input logic [15:0] a, input logic [15:0] d, input logic w,
                         output logic hit);
        @(negedge core_clk);
        io_req <= '{addr: a, wdata: d, wide: w, wr: 1'b1, rd: 1'b0};
        #1 hit = io_hit;
        @(negedge core_clk);
        io_req <= '0;
    endtask : io_wr

    // answer must come exactly one cycle on, else the byte reads as x
    task automatic io_rd(input logic [15:0] a, output logic [7:0] q, output logic hit);
        @(negedge core_clk);
        io_req <= '{addr: a, wdata: 16'h0000, wide: 1'b0, wr: 1'b0, rd: 1'b1};
        #1 hit = io_hit;
        @(negedge core_clk);
        q = (io_rvalid === 1'b1) ? io_rdata : 8'hxx;
        io_req <= '0;
    endtask : io_rd

    // handler borrows an index, then puts the old one back
    task automatic isr(input logic [15:0] a, input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] saved;
        logic       h;
        io_rd(a, saved, h);
        io_wr(a, {8'h00, idx}, 1'b0, h);
        io_wr(a + 16'h0001, {8'h00, d}, 1'b0, h);
        io_wr(a, {8'h00, saved}, 1'b0, h);
    endtask : isr
endmodule : irp_host_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    logic                                 core_clk     = 1'b0;
    logic                                 rst_b        = 1'b0;
    logic                                 color_mode   = 1'b0;
    logic                                 card_present = 1'b1;
    irp_pkg::irp_io_req_t                 io_req;
    logic                                 io_hit;
    logic                                 io_rvalid;
    logic [7:0]                           io_rdata;
    irp_pkg::irp_space_acc_t [3:0]        space_acc;
    logic [3:0][7:0]                      space_rdata;
    irp_pkg::irp_group_t                  setup_group;
    logic                                 setup_card_cfg;
    logic [7:0]                           mem [4][256];
    logic [15:0]                          idxp [4] = '{16'h0022, 16'h0070, 16'h03b4, 16'h03e0};
    int                                   err_total = 0;
    int                                   compares  = 0;
    int                                   cycles    = 0;
    logic [7:0]                           q;
    logic                                 h;

    always #2.5 core_clk = ~core_clk;

    irp_port_decode dut (.core_clk(core_clk), .rst_b(rst_b), .io_req(io_req),
        .io_hit(io_hit), .io_rvalid(io_rvalid), .io_rdata(io_rdata),
        .color_mode(color_mode), .card_present(card_present), .space_acc(space_acc),
        .space_rdata(space_rdata), .setup_group(setup_group),
        .setup_card_cfg(setup_card_cfg));

    irp_host_model host (.core_clk(core_clk), .io_req(io_req), .io_hit(io_hit),
        .io_rvalid(io_rvalid), .io_rdata(io_rdata));

    // far-side register files: write on the strobe edge, comb read
    always @(posedge core_clk) begin
        for (int s = 0; s < 4; s++)
            if (space_acc[s].wr === 1'b1) mem[s][space_acc[s].index] <= space_acc[s].wdata;
    end
    always_comb begin
        for (int s = 0; s < 4; s++) space_rdata[s] = mem[s][space_acc[s].index];
    end

    // hang guard, far above the roughly 160 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            summarize();
        end
    end

    task automatic fail(input logic [7:0] got, input logic [7:0] exp);
        err_total++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    endtask : fail

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) fail(got, exp);
    endtask : chk_byte

    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) fail({7'h00, got}, {7'h00, exp});
    endtask : chk_flag

    task automatic chk_group(input irp_pkg::irp_group_t got, input logic [4:0] exp);
        compares++;
        if (got !== irp_pkg::irp_group_t'(exp)) fail({3'h0, got}, {3'h0, exp});
    endtask : chk_group

    // index registers come out of reset at zero
    task automatic t_reset;
        for (int i = 0; i < 4; i++) begin
            host.io_rd(idxp[i], q, h);
            chk_byte(q, 8'h00);
        end
        chk_group(setup_group, 5'd0);
    endtask : t_reset

    // each space: index, data, read back; indexes held apart per space
    task automatic t_spaces;
        for (int i = 0; i < 4; i++) begin
            host.io_wr(idxp[i], 16'h0005 + 16'(i), 1'b0, h);
            chk_flag(h, 1'b1);
            host.io_wr(idxp[i] + 16'h0001, 16'h00a0 + 16'(i), 1'b0, h);
            chk_flag(h, 1'b1);
            host.io_rd(idxp[i] + 16'h0001, q, h);
            chk_byte(q, 8'ha0 + 8'(i));
        end
        for (int i = 0; i < 4; i++) begin
            host.io_rd(idxp[i], q, h);
            chk_byte(q, 8'h05 + 8'(i));
        end
    endtask : t_spaces

    // last time register and both ends of the battery bytes
    task automatic t_ram;
        logic [7:0] ix [3] = '{8'h0d, 8'h0e, 8'h7f};
        for (int i = 0; i < 3; i++) begin
            host.io_wr(16'h0070, {8'h00, ix[i]}, 1'b0, h);
            host.io_wr(16'h0071, 16'h0011 * 16'(i + 1), 1'b0, h);
        end
        for (int i = 0; i < 3; i++) begin
            host.io_wr(16'h0070, {8'h00, ix[i]}, 1'b0, h);
            host.io_rd(16'h0071, q, h);
            chk_byte(q, 8'h11 * 8'(i + 1));
        end
    endtask : t_ram

    // graphics pair moves with the mode; card pair and long addresses refused
    task automatic t_decode;
        for (int m = 0; m < 2; m++) begin
            @(negedge core_clk) color_mode = m[0];
            host.io_rd(16'h03b4, q, h);
            chk_flag(h, ~m[0]);
            host.io_rd(16'h03d4, q, h);
            chk_flag(h, m[0]);
            if (m == 1) chk_byte(q, 8'h07);
        end
        host.io_wr(16'h03b4, 16'h0055, 1'b0, h);
        chk_flag(h, 1'b0);
        host.io_rd(16'h03d4, q, h);
        chk_byte(q, 8'h07);
        @(negedge core_clk) card_present = 1'b0;
        host.io_rd(16'h03e0, q, h);
        chk_flag(h, 1'b0);
        chk_byte(q, 8'h00);
        host.io_rd(16'h03e1, q, h);
        chk_flag(h, 1'b0);
        host.io_wr(16'h03e0, 16'h0044, 1'b0, h);
        @(negedge core_clk) card_present = 1'b1;
        host.io_rd(16'h03e0, q, h);
        chk_byte(q, 8'h08);
        host.io_wr(16'h1022, 16'h0077, 1'b0, h);
        chk_flag(h, 1'b0);
        host.io_rd(16'h0022, q, h);
        chk_byte(q, 8'h05);
    endtask : t_decode

    // one 16-bit write stores 81h at setup index 65h
    task automatic t_wide;
        host.io_wr(16'h0022, 16'h8165, 1'b1, h);
        chk_group(setup_group, 5'd8);
        host.io_rd(16'h0022, q, h);
        chk_byte(q, 8'h65);
        host.io_rd(16'h0023, q, h);
        chk_byte(q, 8'h81);
    endtask : t_wide

    // group starts, a few last members, card config flag
    task automatic t_groups;
        logic [7:0] gi [22] = '{8'h00, 8'h07, 8'h08, 8'h10, 8'h20, 8'h30, 8'h38, 8'h40,
            8'h50, 8'h60, 8'h70, 8'h80, 8'h88, 8'h90, 8'ha0, 8'hc0, 8'hd0, 8'he0, 8'hea,
            8'hf0, 8'hfe, 8'hff};
        int         ge [22] = '{0, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15,
            16, 17, 18, 18, 19};
        for (int k = 0; k < 22; k++) begin
            host.io_wr(16'h0022, {8'h00, gi[k]}, 1'b0, h);
            chk_group(setup_group, 5'(ge[k]));
            chk_flag(setup_card_cfg, gi[k] >= 8'hf0 && gi[k] != 8'hff);
        end
    endtask : t_groups

    // a handler in mid-sequence must not disturb the selected register
    task automatic t_isr;
        host.io_wr(16'h0022, 16'h0040, 1'b0, h);
        host.io_wr(16'h0023, 16'h003c, 1'b0, h);
        host.isr(16'h0022, 8'h70, 8'h99);
        host.io_rd(16'h0023, q, h);
        chk_byte(q, 8'h3c);
        host.io_rd(16'h0022, q, h);
        chk_byte(q, 8'h40);
    endtask : t_isr

    task automatic summarize;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // reset for four cycles, released away from the sampling edge
    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk) rst_b = 1'b1;
        t_reset();
        t_spaces();
        t_ram();
        t_decode();
        t_wide();
        t_groups();
        t_isr();
        summarize();
    end
endmodule : tb_top
